/* File: dv/gdio_board_model.sv */
// board logic on the general pins
module gdio_board_model (
  // device side
  input wire logic [7:0] oe_n_in,
  input wire logic [7:0] dev_in,
  // board side
  input wire logic [7:0] board_in,
  output logic [7:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // board only drives released lines, so no contention on the wire
  assign pin_out = (~oe_n_in & dev_in) | (oe_n_in & board_in);
endmodule

/* File: dv/gdio_checker.sv */
// concurrent checks on the pin block ports
`include "gdio_defines.svh"

module gdio_checker #(
  parameter int PIN_W = 8,
  parameter int STREAM_W = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register bus
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [`GDIO_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_bvalid_out,
  // pins
  input wire logic [PIN_W-1:0] general_pin_in,
  input wire logic [PIN_W-1:0] general_pin_out,
  input wire logic [PIN_W-1:0] general_pin_oe_n_out,
  input wire logic [STREAM_W-1:0] stream_data_oe_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] idx_reg;
  logic [PIN_W-1:0] last_reg;
  logic [2:0] quiet_reg;

  // read index and pin quiet time; level checks need settled pins past the synchroniser
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idx_reg <= '0;
      last_reg <= '0;
      quiet_reg <= '0;
    end else begin
      if (s_axi_arvalid_in && s_axi_arready_out) idx_reg <= s_axi_araddr_in[11:2];
      last_reg <= general_pin_in;
      quiet_reg <= (general_pin_in != last_reg) ? 3'h0 : quiet_reg + {2'h0, quiet_reg != 3'h7};
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_PIN1_FLOAT:
    assert property (general_pin_oe_n_out[1] && !general_pin_out[1]) else $error("pin one driven");
  AST_RESET_STATE:
    assert property ($rose(rst_n_in) |-> general_pin_oe_n_out == '1 && stream_data_oe_n_out == '1)
    else $error("pins not floating after reset");
  AST_DIR_BY_WRITE:
    assert property (!$stable(general_pin_oe_n_out) |-> $rose(s_axi_bvalid_out))
    else $error("direction changed without write");
  AST_OUT_BY_WRITE:
    assert property (!$stable(general_pin_out) |-> $rose(s_axi_bvalid_out))
    else $error("drive value changed without write");
  AST_EN_BY_WRITE:
    assert property (!$stable(stream_data_oe_n_out) |-> $rose(s_axi_bvalid_out))
    else $error("stream enable changed without write");
  AST_READ_DIR:
    assert property ($rose(s_axi_rvalid_out) && idx_reg == `GDIO_IDX_DIR
      |-> s_axi_rdata_out[7:0] == general_pin_oe_n_out) else $error("direction read differs");
  AST_READ_OUT:
    assert property ($rose(s_axi_rvalid_out) && idx_reg == `GDIO_IDX_OUT_DATA
      |-> s_axi_rdata_out[7:0] == general_pin_out) else $error("drive value read differs");
  AST_READ_EN:
    assert property ($rose(s_axi_rvalid_out) && idx_reg == `GDIO_IDX_STREAM_EN
      |-> s_axi_rdata_out[7:0] == ~stream_data_oe_n_out) else $error("stream enable read differs");
  AST_READ_LEVEL:
    assert property ($rose(s_axi_rvalid_out) && idx_reg == `GDIO_IDX_LEVEL && quiet_reg >= 3'h3
      && $stable(general_pin_in) |-> s_axi_rdata_out[7:0] == (general_pin_in & 8'hfd))
    else $error("level read differs from pins");
endmodule

bind gdio_top gdio_checker #(.PIN_W(PIN_W), .STREAM_W(STREAM_W)) gdio_checker_inst (
  .clk_in, .rst_n_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_araddr_in,
  .s_axi_rvalid_out, .s_axi_rdata_out, .s_axi_bvalid_out, .general_pin_in,
  .general_pin_out, .general_pin_oe_n_out, .stream_data_oe_n_out);

/* File: dv/gdio_top_bench.sv */
// self-checking bench for the pin and stream enable block
module gdio_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, rst_n_in = 0, aw_v = 0, w_v = 0, b_rdy = 0, ar_v = 0, r_rdy = 0;
  logic [11:0] aw_a = 12'h000, ar_a = 12'h000;
  logic [31:0] w_d = 32'h0000_0000, rdata;
  logic [3:0] w_s = 4'h1;
  logic [7:0] board = 8'h00, s_in = 8'h00, p_oe_n, p_out, pins, s_out, s_oe_n;
  logic awr, wrd, bv, arr, rv;
  logic [1:0] bresp, rresp;
  int err_count = 0, total_checks = 0, cyc = 0, dir_m = 255, out_m = 0, en_m = 0, lvl;

  gdio_top gdio_top_inst (
    .clk_in, .rst_n_in, .s_axi_awvalid_in(aw_v), .s_axi_awready_out(awr),
    .s_axi_awaddr_in(aw_a), .s_axi_wvalid_in(w_v), .s_axi_wready_out(wrd),
    .s_axi_wdata_in(w_d), .s_axi_wstrb_in(w_s), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(b_rdy), .s_axi_bresp_out(bresp), .s_axi_arvalid_in(ar_v),
    .s_axi_arready_out(arr), .s_axi_araddr_in(ar_a), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(r_rdy), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .general_pin_in(pins), .general_pin_out(p_out), .general_pin_oe_n_out(p_oe_n),
    .stream_data_in(s_in), .stream_data_out(s_out), .stream_data_oe_n_out(s_oe_n));
  gdio_board_model gdio_board_model_inst (
    .oe_n_in(p_oe_n), .dev_in(p_out), .board_in(board), .pin_out(pins));

  // clock and hang guard
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: resp %h expected %h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    aw_v <= 1;
    w_v <= 1;
    aw_a <= a;
    w_d <= d;
    b_rdy <= 1;
    do begin
      @(posedge clk_in);
      if (awr) aw_v <= 0;
      if (wrd) w_v <= 0;
    end while (bv !== 1'b1);
    chk_resp(bresp, er);
    b_rdy <= 0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    ar_v <= 1;
    ar_a <= a;
    r_rdy <= 1;
    do begin
      @(posedge clk_in);
      if (arr) ar_v <= 0;
    end while (rv !== 1'b1);
    chk_val(rdata, ed);
    chk_resp(rresp, er);
    r_rdy <= 0;
    @(posedge clk_in);
  endtask

  // pin enables and drive values against the shadow registers
  task automatic chk_pins();
    chk_val(p_oe_n, dir_m | 2);
    chk_val(p_out, out_m & 8'hfd);
    chk_val(s_oe_n, ~en_m & 8'hff);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // reset values, random configurations, refusals, then a second reset
  initial begin
    void'($urandom(32'h2769_d0f3));
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1;
    @(posedge clk_in);
    chk_pins();
    rd(12'h140, 0, 0);
    rd(12'h144, 255, 0);
    rd(12'h148, 0, 0);
    rd(12'h14c, 0, 0);
    for (int i = 0; i < 10; i++) begin
      out_m = (i == 0) ? 255 : $urandom & 255;
      dir_m = (i == 0) ? 0 : $urandom & 255;
      en_m = (i == 0) ? 255 : $urandom & 255;
      wr(12'h140, out_m, 0);
      wr(12'h144, dir_m, 0);
      wr(12'h14c, en_m, 0);
      board <= 8'($urandom);
      s_in <= 8'($urandom);
      repeat (3) @(posedge clk_in);
      chk_pins();
      chk_val(s_out, s_in);
      lvl = ((~(dir_m | 2) & out_m) | ((dir_m | 2) & board)) & 8'hfd;
      rd(12'h140, out_m & 8'hfd, 0);
      rd(12'h144, dir_m | 2, 0);
      rd(12'h148, lvl, 0);
      rd(12'h14c, en_m, 0);
    end
    // a write without byte lane 0 is answered but leaves the register alone
    w_s <= 4'h0;
    wr(12'h144, ~dir_m, 0);
    w_s <= 4'h1;
    chk_pins();
    wr(12'h148, 32'h0000_005a, 2'b10);
    rd(12'h148, lvl, 0);
    wr(12'h200, 32'h0000_005a, 2'b10);
    rd(12'h200, 0, 2'b10);
    chk_pins();
    rst_n_in <= 0;
    dir_m = 255;
    out_m = 0;
    en_m = 0;
    repeat (2) @(posedge clk_in);
    chk_pins();
    rst_n_in <= 1;
    repeat (2) @(posedge clk_in);
    chk_pins();
    rd(12'h140, 0, 0);
    rd(12'h144, 255, 0);
    rd(12'h14c, 0, 0);
    stop_test();
  end
endmodule

/* File: verilog/gdio_axil_slave.sv */
// axi4-lite slave front end: handshakes, write pulse and registered read answer
`include "gdio_defines.svh"

module gdio_axil_slave (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // write address and data channels
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [`GDIO_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  // write response channel
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // read channels
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [`GDIO_ADDR_W-1:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // register file side
  output gdio_pkg::gdio_wr_s wr_out,
  input wire logic wr_hit_in,
  output logic [9:0] rd_idx_out,
  input gdio_pkg::gdio_rd_s rd_in
);
  import gdio_pkg::*;

  logic aw_held_reg;
  logic w_held_reg;
  logic [9:0] aw_idx_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
  wire w_take = s_axi_wvalid_in && s_axi_wready_out;
  wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;

  // each side is taken once, in either order; the write waits while a response is pending
  assign s_axi_awready_out = !aw_held_reg;
  assign s_axi_wready_out = !w_held_reg;
  assign s_axi_arready_out = !rvalid_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;

  // only byte lane 0 carries register bits; without it the write is a no-op
  assign wr_out.en = do_write && w_lane0_reg;
  assign wr_out.idx = aw_idx_reg;
  assign wr_out.data = w_data_reg;
  assign rd_idx_out = s_axi_araddr_in[11:2];

  // write channel capture and response
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= 10'h000;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `GDIO_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr_in[11:2];
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in[7:0];
        w_lane0_reg <= s_axi_wstrb_in[0];
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit_in ? `GDIO_RESP_OKAY : `GDIO_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_in) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read answer is sampled at the address handshake, one cycle later
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= `GDIO_READ_UNMAPPED;
      rresp_reg <= `GDIO_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_in.hit ? {24'h00_0000, rd_in.data} : `GDIO_READ_UNMAPPED;
      rresp_reg <= rd_in.hit ? `GDIO_RESP_OKAY : `GDIO_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

/* File: verilog/gdio_defines.svh */
// register indices, reset values, field positions and bus constants for the pin block
`ifndef GDIO_DEFINES_SVH
`define GDIO_DEFINES_SVH

// register indices as printed; the byte address is four times the index
`define GDIO_IDX_OUT_DATA 10'h050
`define GDIO_IDX_DIR 10'h051
`define GDIO_IDX_LEVEL 10'h052
`define GDIO_IDX_STREAM_EN 10'h053

// reset values
`define GDIO_RST_OUT_DATA 8'h00
`define GDIO_RST_DIR 8'hff
`define GDIO_RST_LEVEL 8'h00
`define GDIO_RST_STREAM_EN 8'h00
`define GDIO_RST_STREAM_DATA 8'h00

// field layout: bit 1 carries no general-purpose pin
`define GDIO_RSVD_BIT 1
`define GDIO_PIN_MASK 8'hfd

// bus geometry and answers
`define GDIO_ADDR_W 12
`define GDIO_RESP_OKAY 2'b00
`define GDIO_RESP_SLVERR 2'b10
`define GDIO_READ_UNMAPPED 32'h0000_0000

// pin synchroniser depth
`define GDIO_SYNC_STAGES 2

`endif

/* File: verilog/gdio_pkg.sv */
// types shared by the pin block and its register bus slave
package gdio_pkg;

  // register selected by a decoded word index
  typedef enum logic [2:0] {
    GDIO_SEL_OUT_DATA,
    GDIO_SEL_DIR,
    GDIO_SEL_LEVEL,
    GDIO_SEL_STREAM_EN,
    GDIO_SEL_NONE
  } gdio_sel_e;

  // one register write, presented for a single cycle
  typedef struct packed {
    logic en;
    logic [9:0] idx;
    logic [7:0] data;
  } gdio_wr_s;

  // read lookup: index out, data and hit back the same cycle
  typedef struct packed {
    logic hit;
    logic [7:0] data;
  } gdio_rd_s;

endpackage

/* File: verilog/gdio_top.sv */
// general-purpose pin and stream data output-enable block with its register file
//
// What this block does
// - each general pin 7..2 and 0 is driven when its direction bit is 0
// - direction bit 1 means input with driver off; all direction bits reset to 1
// - bit 1 of direction and level registers is reserved, no pin 1 function
// - read-only level register shows current pin levels in bits 7..2, 0; resets 00h
// - stream enable bit n turns stream data pin n driver on (1) or off (0)
// - all stream data enables are 0 after reset, so outputs start disabled
// - an output pin drives its bit from the output-data register below direction
`include "gdio_defines.svh"

module gdio_top #(
  parameter int PIN_W = 8,
  parameter int STREAM_W = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [`GDIO_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  // axi4-lite write response
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // axi4-lite read
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [`GDIO_ADDR_W-1:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // general pins, three-signal form; enable low means driving
  input wire logic [PIN_W-1:0] general_pin_in,
  output logic [PIN_W-1:0] general_pin_out,
  output logic [PIN_W-1:0] general_pin_oe_n_out,
  // stream data from the formatter, same clock
  input wire logic [STREAM_W-1:0] stream_data_in,
  // stream data pins; enable low means driving
  output logic [STREAM_W-1:0] stream_data_out,
  output logic [STREAM_W-1:0] stream_data_oe_n_out
);
  import gdio_pkg::*;

  // map a word index onto a register; used by both the write and the read path
  function automatic gdio_sel_e decode_sel(input logic [9:0] idx);
    unique case (idx)
      `GDIO_IDX_OUT_DATA: decode_sel = GDIO_SEL_OUT_DATA;
      `GDIO_IDX_DIR: decode_sel = GDIO_SEL_DIR;
      `GDIO_IDX_LEVEL: decode_sel = GDIO_SEL_LEVEL;
      `GDIO_IDX_STREAM_EN: decode_sel = GDIO_SEL_STREAM_EN;
      default: decode_sel = GDIO_SEL_NONE;
    endcase
  endfunction

  // register file state
  logic [PIN_W-1:0] out_data_reg;
  logic [PIN_W-1:0] direction_reg;
  logic [STREAM_W-1:0] stream_en_reg;
  logic [STREAM_W-1:0] stream_data_reg;
  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] level_reg;
  logic [PIN_W-1:0] out_data_next;
  logic [PIN_W-1:0] direction_next;
  logic [STREAM_W-1:0] stream_en_next;

  // bus side wiring
  gdio_wr_s wr;
  gdio_rd_s rd;
  logic [9:0] rd_idx;
  gdio_sel_e wr_sel;
  gdio_sel_e rd_sel;
  logic wr_hit;
  logic wr_out_data;
  logic wr_dir;
  logic wr_stream_en;

  gdio_axil_slave u_slave (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out),
    .s_axi_awaddr_in(s_axi_awaddr_in),
    .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out),
    .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in),
    .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in),
    .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out),
    .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in),
    .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out),
    .wr_out(wr),
    .wr_hit_in(wr_hit),
    .rd_idx_out(rd_idx),
    .rd_in(rd)
  );

  // write decode; the level register is read-only, so a write there is refused
  assign wr_sel = decode_sel(wr.idx);
  assign wr_hit = (wr_sel != GDIO_SEL_NONE) && (wr_sel != GDIO_SEL_LEVEL);
  assign wr_out_data = wr.en && (wr_sel == GDIO_SEL_OUT_DATA);
  assign wr_dir = wr.en && (wr_sel == GDIO_SEL_DIR);
  assign wr_stream_en = wr.en && (wr_sel == GDIO_SEL_STREAM_EN);

  // next values; reserved bit 1 keeps its reset value whatever is written
  assign out_data_next = (wr.data & `GDIO_PIN_MASK) | (`GDIO_RST_OUT_DATA & ~`GDIO_PIN_MASK);
  assign direction_next = (wr.data & `GDIO_PIN_MASK) | (`GDIO_RST_DIR & ~`GDIO_PIN_MASK);
  assign stream_en_next = wr.data;

  // software-written control registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_data_reg <= `GDIO_RST_OUT_DATA;
      direction_reg <= `GDIO_RST_DIR;
      stream_en_reg <= `GDIO_RST_STREAM_EN;
    end else begin
      if (wr_out_data) begin
        out_data_reg <= out_data_next;
      end
      if (wr_dir) begin
        direction_reg <= direction_next;
      end
      if (wr_stream_en) begin
        stream_en_reg <= stream_en_next;
      end
    end
  end

  // pin levels arrive from the board asynchronously: two flops before any reader
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= `GDIO_RST_LEVEL;
      level_reg <= `GDIO_RST_LEVEL;
    end else begin
      sync1_reg <= general_pin_in;
      level_reg <= sync1_reg;
    end
  end

  // stream data is re-timed so the pin sees a flop, not formatter logic
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stream_data_reg <= `GDIO_RST_STREAM_DATA;
    end else begin
      stream_data_reg <= stream_data_in;
    end
  end

  // read lookup; the level view masks bit 1 since no pin stands behind it
  assign rd_sel = decode_sel(rd_idx);
  assign rd.hit = (rd_sel != GDIO_SEL_NONE);
  assign rd.data = (rd_sel == GDIO_SEL_OUT_DATA) ? out_data_reg :
                   (rd_sel == GDIO_SEL_DIR) ? direction_reg :
                   (rd_sel == GDIO_SEL_LEVEL) ? (level_reg & `GDIO_PIN_MASK) :
                   (rd_sel == GDIO_SEL_STREAM_EN) ? stream_en_reg : 8'h00;

  // per-pin drivers; pin 1 is never driven here, whatever the registers hold
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_pin
      if (gi == `GDIO_RSVD_BIT) begin : g_rsvd
        assign general_pin_out[gi] = 1'b0;
        assign general_pin_oe_n_out[gi] = 1'b1;
      end else begin : g_gp
        // direction 0 drives the data bit, 1 floats the pin
        assign general_pin_out[gi] = out_data_reg[gi];
        assign general_pin_oe_n_out[gi] = direction_reg[gi];
      end
    end
    for (gi = 0; gi < STREAM_W; gi++) begin : g_stream
      assign stream_data_out[gi] = stream_data_reg[gi];
      assign stream_data_oe_n_out[gi] = !stream_en_reg[gi];
    end
  endgenerate

endmodule
